// ### ssitp_map.svh
// Constants of the strap-sampled I2C target port.
// Assumes a 200 MHz system clock and four-level pins given as 2-bit codes.
`ifndef SSITP_MAP_SVH
`define SSITP_MAP_SVH
`define SSITP_CLK_MHZ      200
`define SSITP_PG_MAX_US    500
`define SSITP_PG_CYC       (`SSITP_PG_MAX_US * `SSITP_CLK_MHZ \
                            - `SSITP_SYNC_LAT)
`define SSITP_CFG_SETUP_US 250
`define SSITP_CFG_HOLD_US  10
`define SSITP_DEB_MAX_MS   16
`define SSITP_SYNC_LAT     8
`define SSITP_DEB_CYC      (`SSITP_DEB_MAX_MS * 1000 * `SSITP_CLK_MHZ \
                            - `SSITP_SYNC_LAT)
`define SSITP_OFS_GEN      8'h0A
`define SSITP_OFS_VID01    8'h10
`define SSITP_OFS_VID23    8'h11
`define SSITP_OFS_USBG     8'h20
`define SSITP_OFS_EVT      8'h21
`define SSITP_OFS_SET      8'h22
`define SSITP_RST_GEN      8'h01
`define SSITP_GEN_RW       8'h3F
`define SSITP_GEN_OVR      4
`define SSITP_EVT_CLR      8'h03
`define SSITP_ALL          8'hFF
`define SSITP_NONE         8'h00
`define SSITP_AHI_0        5'h11
`define SSITP_AHI_R        5'h08
`define SSITP_AHI_F        5'h04
`define SSITP_AHI_1        5'h03
`endif

// ### ssitp_pkg.sv
// Types shared by the strap-sampled I2C target port.
// Assumes four-level pins are presented as 2-bit level codes.
package ssitp_pkg;
    // Four-level pin codes: tied low, resistor low, floating, tied high.
    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_RES = 2'h1,
        LVL_FLT = 2'h2,
        LVL_HI  = 2'h3
    } ssitp_lvl_e;
    // Strap group; each gain pair is {pin1 code, pin0 code}.
    typedef struct packed {
        logic       serial_sel;
        logic [3:0] downstream;
        logic [3:0] upstream;
        logic [3:0] video;
    } ssitp_strap_s;
    // All pins that enter from outside the clock domain.
    typedef struct packed {
        logic         scl;
        logic         sda;
        logic         supply_ok;
        logic [1:0]   lane;
        logic         orient;
        ssitp_strap_s strap;
    } ssitp_pins_s;
    // Transfer states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h3,
        ST_SUB  = 4'h2,
        ST_SACK = 4'h6,
        ST_WDAT = 4'h7,
        ST_WACK = 4'h5,
        ST_RDAT = 4'h4,
        ST_RACK = 4'hC,
        ST_SKIP = 4'hD
    } ssitp_state_e;
endpackage

// ### ssitp_top.sv
// Strap sampling, pin debouncing and I2C target register port.
// Assumes SCL and SDA are open-drain wires resolved outside.
`include "ssitp_map.svh"
module ssitp_top #(
    parameter logic [16:0] PG_CYC  = 17'(`SSITP_PG_CYC),
    parameter logic [21:0] DEB_CYC = 22'(`SSITP_DEB_CYC)
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        SUPPLY_OK,
    input  wire logic        SCL,
    input  wire logic        SDA_I,
    output wire logic        SDA_O,
    output wire logic        SDA_OE_N,
    input  wire logic [1:0]  LANE_CONFIG_PINS,
    input  wire logic        ORIENTATION_PIN,
    input  wire logic        SERIAL_CFG_STRAP,
    input  wire logic [3:0]  DOWNSTREAM_GAIN_STRAP,
    input  wire logic [3:0]  UPSTREAM_GAIN_STRAP,
    input  wire logic [3:0]  VIDEO_LANE_GAIN_STRAP,
    output wire logic        POWER_GOOD,
    output wire logic        SERIAL_CFG_SEL,
    output wire logic [1:0]  LANE_CONFIG,
    output wire logic        ORIENTATION,
    output wire logic [1:0]  LANE_SEL,
    output wire logic        FLIP_SEL,
    output wire logic        HPD_FORCE,
    output wire logic        HPD_SWAP,
    output wire logic        GAIN_OVERRIDE,
    output wire logic [3:0]  DOWNSTREAM_GAIN,
    output wire logic [3:0]  UPSTREAM_GAIN,
    output wire logic [15:0] VIDEO_GAIN
);
    ssitp_pkg::ssitp_pins_s  pin_raw;
    ssitp_pkg::ssitp_pins_s  s1_q;
    ssitp_pkg::ssitp_pins_s  s2_q;
    ssitp_pkg::ssitp_pins_s  s3_q;
    ssitp_pkg::ssitp_pins_s  flt_q;
    ssitp_pkg::ssitp_strap_s strap_q;
    ssitp_pkg::ssitp_state_e st_q;
    logic        scl_p_q;
    logic        sda_p_q;
    logic [16:0] pg_cnt_q;
    logic        pg_q;
    logic [2:0]  cand_q;
    logic [2:0]  stab_q;
    logic [21:0] deb_cnt_q;
    logic [1:0]  hw_evt;
    logic [7:0]  shreg_q;
    logic [2:0]  bit_q;
    logic        done_q;
    logic        rw_q;
    logic        ack_q;
    logic [7:0]  ptr_q;
    logic        oe_n_q;
    logic        sda_o_q;
    logic [7:0]  gen_q;
    logic [15:0] vid_q;
    logic [7:0]  usb_q;
    logic [1:0]  evt_q;
    logic [7:0]  set_q;
    logic [3:0]  dn_out_q;
    logic [3:0]  up_out_q;
    logic [15:0] vid_out_q;
    logic [7:0]  rdata;
    logic [6:0]  my_addr;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        wr_stb;
    logic        pg_fire;
    logic        ovr;

    // Merges a bus write by field type: plain, set or clear bits.
    function automatic logic [7:0] apply_wr(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic [7:0] rw,
        input logic [7:0] sm,
        input logic [7:0] cm
    );
        logic [7:0] keep;
        keep = ~(rw | sm | cm);
        return (wd & rw) | ((old | wd) & sm) | (old & ~wd & cm)
            | (old & keep);
    endfunction

    // Maps the high address strap code to the upper five bits.
    function automatic logic [4:0] addr_hi(input logic [1:0] lvl);
        case (lvl)
            ssitp_pkg::LVL_LOW: addr_hi = `SSITP_AHI_0;
            ssitp_pkg::LVL_RES: addr_hi = `SSITP_AHI_R;
            ssitp_pkg::LVL_FLT: addr_hi = `SSITP_AHI_F;
            default:            addr_hi = `SSITP_AHI_1;
        endcase
    endfunction

    // Gathers the asynchronous pins into one vector.
    always_comb begin
        pin_raw.scl              = SCL;
        pin_raw.sda              = SDA_I;
        pin_raw.supply_ok        = SUPPLY_OK;
        pin_raw.lane             = LANE_CONFIG_PINS;
        pin_raw.orient           = ORIENTATION_PIN;
        pin_raw.strap.serial_sel = SERIAL_CFG_STRAP;
        pin_raw.strap.downstream = DOWNSTREAM_GAIN_STRAP;
        pin_raw.strap.upstream   = UPSTREAM_GAIN_STRAP;
        pin_raw.strap.video      = VIDEO_LANE_GAIN_STRAP;
    end

    // Three-stage synchroniser for every pin.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            flt_q <= '0;
        end else begin
            flt_q <= ssitp_pkg::ssitp_pins_s'((s2_q & s3_q)
                | (flt_q & (s2_q | s3_q)));
        end
    end

    // Internal power-good counts from a valid supply.
    assign pg_fire = flt_q.supply_ok & ~pg_q
        & (pg_cnt_q == 17'(PG_CYC - 17'h1));
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !flt_q.supply_ok) begin
            pg_cnt_q <= '0;
            pg_q     <= 1'b0;
        end else if (pg_fire) begin
            pg_q <= 1'b1;
        end else if (!pg_q) begin
            pg_cnt_q <= 17'(pg_cnt_q + 17'h1);
        end
    end

    // Straps are latched on the power-good edge; the board keeps them
    // steady around it.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            strap_q <= '0;
        end else if (pg_fire) begin
            strap_q <= flt_q.strap;
        end
    end

    // Debounce: a candidate level must hold for the whole count.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cand_q    <= '0;
            stab_q    <= '0;
            deb_cnt_q <= '0;
        end else if (cand_q != {flt_q.orient, flt_q.lane}) begin
            cand_q    <= {flt_q.orient, flt_q.lane};
            deb_cnt_q <= '0;
        end else if (cand_q == stab_q) begin
            deb_cnt_q <= '0;
        end else if (deb_cnt_q == 22'(DEB_CYC - 22'h1)) begin
            stab_q    <= cand_q;
            deb_cnt_q <= '0;
        end else begin
            deb_cnt_q <= 22'(deb_cnt_q + 22'h1);
        end
    end
    assign hw_evt = {cand_q[2] != stab_q[2], cand_q[1:0] != stab_q[1:0]}
        & {2{cand_q == {flt_q.orient, flt_q.lane}
        && deb_cnt_q == 22'(DEB_CYC - 22'h1)}};

    // Bus edges and start and stop conditions.
    assign scl_rise = flt_q.scl & ~scl_p_q;
    assign scl_fall = ~flt_q.scl & scl_p_q;
    assign start_c  = scl_p_q & flt_q.scl & sda_p_q & ~flt_q.sda;
    assign stop_c   = scl_p_q & flt_q.scl & ~sda_p_q & flt_q.sda;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= flt_q.scl;
            sda_p_q <= flt_q.sda;
        end
    end

    // Strapped target address.
    assign my_addr = {addr_hi(strap_q.video[1:0]),
        strap_q.upstream[1:0]};
    assign ovr     = gen_q[`SSITP_GEN_OVR];
    assign wr_stb  = (st_q == ssitp_pkg::ST_WDAT) & scl_fall & done_q;

    // Read data at the pointer; gain fields follow the override bit.
    always_comb begin
        case (ptr_q)
            `SSITP_OFS_GEN:   rdata = gen_q;
            `SSITP_OFS_VID01: rdata = ovr ? vid_q[7:0]
                : {2{strap_q.video}};
            `SSITP_OFS_VID23: rdata = ovr ? vid_q[15:8]
                : {2{strap_q.video}};
            `SSITP_OFS_USBG:  rdata = ovr ? usb_q
                : {strap_q.upstream, strap_q.downstream};
            `SSITP_OFS_EVT:   rdata = {3'h0, stab_q, evt_q};
            `SSITP_OFS_SET:   rdata = set_q;
            default:          rdata = 8'h00;
        endcase
    end

    // Transfer state machine, bit counter and pointer.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st_q    <= ssitp_pkg::ST_IDLE;
            shreg_q <= '0;
            bit_q   <= '0;
            done_q  <= 1'b0;
            rw_q    <= 1'b0;
            ack_q   <= 1'b0;
            ptr_q   <= 8'h00;
            oe_n_q  <= 1'b1;
        end else if (!pg_q || stop_c) begin
            st_q   <= ssitp_pkg::ST_IDLE;
            oe_n_q <= 1'b1;
        end else if (start_c) begin
            st_q   <= ssitp_pkg::ST_ADDR;
            bit_q  <= '0;
            done_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            case (st_q)
                ssitp_pkg::ST_ADDR,
                ssitp_pkg::ST_SUB,
                ssitp_pkg::ST_WDAT: begin
                    if (scl_rise) begin
                        shreg_q <= {shreg_q[6:0], flt_q.sda};
                        bit_q   <= 3'(bit_q + 3'h1);
                        done_q  <= (bit_q == 3'h7);
                    end else if (scl_fall && done_q) begin
                        done_q <= 1'b0;
                        oe_n_q <= 1'b0;
                        if (st_q == ssitp_pkg::ST_ADDR) begin
                            rw_q <= shreg_q[0];
                            if (shreg_q[7:1] == my_addr) begin
                                st_q <= ssitp_pkg::ST_AACK;
                            end else begin
                                st_q   <= ssitp_pkg::ST_SKIP;
                                oe_n_q <= 1'b1;
                            end
                        end else if (st_q == ssitp_pkg::ST_SUB) begin
                            ptr_q <= shreg_q;
                            st_q  <= ssitp_pkg::ST_SACK;
                        end else begin
                            ptr_q <= 8'(ptr_q + 8'h1);
                            st_q  <= ssitp_pkg::ST_WACK;
                        end
                    end
                end
                ssitp_pkg::ST_AACK: begin
                    if (scl_fall && rw_q) begin
                        shreg_q <= rdata;
                        oe_n_q  <= rdata[7];
                        bit_q   <= '0;
                        st_q    <= ssitp_pkg::ST_RDAT;
                    end else if (scl_fall) begin
                        oe_n_q <= 1'b1;
                        bit_q  <= '0;
                        st_q   <= ssitp_pkg::ST_SUB;
                    end
                end
                ssitp_pkg::ST_SACK,
                ssitp_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        oe_n_q <= 1'b1;
                        bit_q  <= '0;
                        st_q   <= ssitp_pkg::ST_WDAT;
                    end
                end
                ssitp_pkg::ST_RDAT: begin
                    if (scl_rise) begin
                        bit_q  <= 3'(bit_q + 3'h1);
                        done_q <= (bit_q == 3'h7);
                    end else if (scl_fall && done_q) begin
                        done_q <= 1'b0;
                        oe_n_q <= 1'b1;
                        ptr_q  <= 8'(ptr_q + 8'h1);
                        st_q   <= ssitp_pkg::ST_RACK;
                    end else if (scl_fall) begin
                        shreg_q <= {shreg_q[6:0], 1'b0};
                        oe_n_q  <= shreg_q[6];
                    end
                end
                ssitp_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        ack_q <= ~flt_q.sda;
                    end else if (scl_fall && ack_q) begin
                        shreg_q <= rdata;
                        oe_n_q  <= rdata[7];
                        bit_q   <= '0;
                        st_q    <= ssitp_pkg::ST_RDAT;
                    end else if (scl_fall) begin
                        st_q <= ssitp_pkg::ST_SKIP;
                    end
                end
                ssitp_pkg::ST_SKIP: begin
                    oe_n_q <= 1'b1;
                end
                default: begin
                    oe_n_q <= 1'b1;
                end
            endcase
        end
    end

    // Data line only ever pulls low; the level register stays zero.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
        end
    end

    // General control register.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            gen_q <= `SSITP_RST_GEN;
        end else if (wr_stb && ptr_q == `SSITP_OFS_GEN) begin
            gen_q <= apply_wr(gen_q, shreg_q, `SSITP_GEN_RW,
                `SSITP_NONE, `SSITP_NONE);
        end
    end

    // Software gain values, used while the override bit is set.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            vid_q <= '0;
            usb_q <= '0;
        end else if (wr_stb) begin
            if (ptr_q == `SSITP_OFS_VID01) begin
                vid_q[7:0] <= apply_wr(vid_q[7:0], shreg_q,
                    `SSITP_ALL, `SSITP_NONE, `SSITP_NONE);
            end
            if (ptr_q == `SSITP_OFS_VID23) begin
                vid_q[15:8] <= apply_wr(vid_q[15:8], shreg_q,
                    `SSITP_ALL, `SSITP_NONE, `SSITP_NONE);
            end
            if (ptr_q == `SSITP_OFS_USBG) begin
                usb_q <= apply_wr(usb_q, shreg_q,
                    `SSITP_ALL, `SSITP_NONE, `SSITP_NONE);
            end
        end
    end

    // Pin change events: hardware sets, a written one clears, set wins.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            evt_q <= '0;
        end else if (wr_stb && ptr_q == `SSITP_OFS_EVT) begin
            evt_q <= 2'(apply_wr({6'h0, evt_q}, shreg_q, `SSITP_NONE,
                `SSITP_NONE, `SSITP_EVT_CLR)) | hw_evt;
        end else begin
            evt_q <= evt_q | hw_evt;
        end
    end

    // Sticky flags that software sets and only reset clears.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            set_q <= '0;
        end else if (wr_stb && ptr_q == `SSITP_OFS_SET) begin
            set_q <= apply_wr(set_q, shreg_q, `SSITP_NONE,
                `SSITP_ALL, `SSITP_NONE);
        end
    end

    // Registered gain outputs from straps or software.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            dn_out_q  <= '0;
            up_out_q  <= '0;
            vid_out_q <= '0;
        end else begin
            dn_out_q  <= ovr ? usb_q[3:0] : strap_q.downstream;
            up_out_q  <= ovr ? usb_q[7:4] : strap_q.upstream;
            vid_out_q <= ovr ? vid_q : {4{strap_q.video}};
        end
    end

    // Outputs, all driven by flip-flops.
    assign SDA_O           = sda_o_q;
    assign SDA_OE_N        = oe_n_q;
    assign POWER_GOOD      = pg_q;
    assign SERIAL_CFG_SEL  = strap_q.serial_sel;
    assign LANE_CONFIG     = stab_q[1:0];
    assign ORIENTATION     = stab_q[2];
    assign LANE_SEL        = gen_q[1:0];
    assign FLIP_SEL        = gen_q[2];
    assign HPD_FORCE       = gen_q[3];
    assign GAIN_OVERRIDE   = gen_q[4];
    assign HPD_SWAP        = gen_q[5];
    assign DOWNSTREAM_GAIN = dn_out_q;
    assign UPSTREAM_GAIN   = up_out_q;
    assign VIDEO_GAIN      = vid_out_q;
endmodule

// ### ssitp_top_properties.sv
// Concurrent checks on the ports of the strap-sampled I2C target port.
// Assumes it is bound into ssitp_top and sees only its ports.
module ssitp_top_properties #(
    parameter logic [16:0] PG_CYC  = 17'h14,
    parameter logic [21:0] DEB_CYC = 22'h10
) (
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        SUPPLY_OK,
    input wire logic        SCL,
    input wire logic        SDA_O,
    input wire logic        SDA_OE_N,
    input wire logic [1:0]  LANE_CONFIG_PINS,
    input wire logic        ORIENTATION_PIN,
    input wire logic        SERIAL_CFG_STRAP,
    input wire logic [3:0]  DOWNSTREAM_GAIN_STRAP,
    input wire logic [3:0]  UPSTREAM_GAIN_STRAP,
    input wire logic        POWER_GOOD,
    input wire logic        SERIAL_CFG_SEL,
    input wire logic [1:0]  LANE_CONFIG,
    input wire logic        ORIENTATION,
    input wire logic        GAIN_OVERRIDE,
    input wire logic [3:0]  DOWNSTREAM_GAIN,
    input wire logic [3:0]  UPSTREAM_GAIN
);
    logic [17:0] pg_q;
    logic [23:0] deb_q;
    logic [2:0]  pins_q;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // Counts supply-valid cycles still waiting for power-good.
    always_ff @(posedge CLK_SYS) begin
        pg_q <= (RST_N && SUPPLY_OK && !POWER_GOOD) ? pg_q + 18'h1 : 18'h0;
    end
    // Remembers the pin levels of the previous cycle.
    always_ff @(posedge CLK_SYS) begin
        pins_q <= {LANE_CONFIG_PINS, ORIENTATION_PIN};
    end
    // Counts cycles that stable pins differ from the debounced levels.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || pins_q != {LANE_CONFIG_PINS, ORIENTATION_PIN} ||
            pins_q == {LANE_CONFIG, ORIENTATION}) begin
            deb_q <= 24'h0;
        end else begin
            deb_q <= deb_q + 24'h1;
        end
    end
    // Strap mode seen for two cycles, and an acknowledge held low.
    sequence s_strap_mode;
        POWER_GOOD && !GAIN_OVERRIDE ##1 POWER_GOOD && !GAIN_OVERRIDE;
    endsequence
    sequence s_low_hold;
        !SDA_OE_N [*8];
    endsequence
    rst_release_a: assert property ($rose(RST_N) |-> SDA_OE_N && !POWER_GOOD)
        else $error("outputs not idle after reset");
    pg_bound_a: assert property (pg_q <= 18'(PG_CYC) + 18'h8)
        else $error("power-good late");
    strap_latch_a: assert property ($rose(POWER_GOOD) |->
        ##1 SERIAL_CFG_SEL == SERIAL_CFG_STRAP)
        else $error("serial select not latched");
    gain_strap_a: assert property (s_strap_mode |->
        {UPSTREAM_GAIN, DOWNSTREAM_GAIN} ==
        {UPSTREAM_GAIN_STRAP, DOWNSTREAM_GAIN_STRAP})
        else $error("gain differs from strap");
    deb_bound_a: assert property (deb_q <= 24'(DEB_CYC) + 24'hA)
        else $error("debounce too slow");
    deb_cause_a: assert property ($changed({LANE_CONFIG, ORIENTATION}) |->
        {LANE_CONFIG, ORIENTATION} == {LANE_CONFIG_PINS, ORIENTATION_PIN})
        else $error("debounced level without cause");
    quiet_pre_pg_a: assert property (!POWER_GOOD && !$past(POWER_GOOD)
        |-> SDA_OE_N)
        else $error("SDA pulled before power-good");
    drive_low_a: assert property (SDA_O == 1'b0)
        else $error("SDA driven high");
    scl_low_chg_a: assert property ($changed(SDA_OE_N) |-> !SCL)
        else $error("SDA changed while SCL high");
    ack_hold_a: assert property ($fell(SDA_OE_N) |-> s_low_hold)
        else $error("SDA low too short");
endmodule
bind ssitp_top ssitp_top_properties #(.PG_CYC(PG_CYC), .DEB_CYC(DEB_CYC))
    props_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SUPPLY_OK(SUPPLY_OK),
    .SCL(SCL), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
    .LANE_CONFIG_PINS(LANE_CONFIG_PINS), .ORIENTATION_PIN(ORIENTATION_PIN),
    .SERIAL_CFG_STRAP(SERIAL_CFG_STRAP),
    .DOWNSTREAM_GAIN_STRAP(DOWNSTREAM_GAIN_STRAP),
    .UPSTREAM_GAIN_STRAP(UPSTREAM_GAIN_STRAP), .POWER_GOOD(POWER_GOOD),
    .SERIAL_CFG_SEL(SERIAL_CFG_SEL), .LANE_CONFIG(LANE_CONFIG),
    .ORIENTATION(ORIENTATION), .GAIN_OVERRIDE(GAIN_OVERRIDE),
    .DOWNSTREAM_GAIN(DOWNSTREAM_GAIN), .UPSTREAM_GAIN(UPSTREAM_GAIN));

// ### ssitp_i2c_ctl.sv
// Behavioural I2C controller that faces the target port.
// Assumes a pulled-up SDA wire and an SCL that only it drives.
module ssitp_i2c_ctl (
    input  wire logic clk,
    input  wire logic sda_oe_n,
    input  wire logic sda_o,
    output logic      scl,
    output wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv_q;
    // The wire is low whenever either party pulls it, else pulled up.
    assign sda = drv_q & (sda_oe_n | sda_o);
    // Idle bus: both lines high, SCL stands still between frames.
    initial begin
        scl = 1'b1;
        drv_q = 1'b1;
    end
    // One quarter of a bit: ten system clocks, so SCL runs at 5 MHz.
    task q;
        repeat (10) @(posedge clk);
    endtask
    // One bit: data set while SCL low, sampled at mid high.
    task bitx(input logic d, output logic s);
        drv_q <= d;
        q();
        scl <= 1'b1;
        q();
        s = sda;
        q();
        scl <= 1'b0;
        q();
    endtask
    // Start condition from idle or as a repeated start.
    task start;
        drv_q <= 1'b1;
        scl <= 1'b1;
        q();
        drv_q <= 1'b0;
        q();
        scl <= 1'b0;
        q();
    endtask
    // Every transfer ends with a stop condition.
    task stop;
        drv_q <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        drv_q <= 1'b1;
        q();
    endtask
    // Sends a byte MSB first and returns the target's acknowledge.
    task wbyte(input logic [7:0] b, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--) bitx(b[i], n);
        bitx(1'b1, n);
        ack = !n;
    endtask
    // Receives a byte; acknowledges unless it is the last wanted.
    task rbyte(input logic last, output logic [7:0] b);
        logic n;
        for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
        bitx(last, n);
    endtask
endmodule

// ### ssitp_top_tb.sv
// Self-checking bench of the strap-sampled I2C target port.
// Assumes the controller model ssitp_i2c_ctl and the bound checker.
module ssitp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DEV = {5'h08, 2'h2}; // High strap R, low F.
    logic        clk, rst_n, supply_ok, orient_pin, scl, sda_oe_n, sda_o;
    logic        pg, sel, flip, gov, orient, a, hpf, hps;
    logic [1:0]  lane_pin, lane_cfg, lane_sel;
    logic [3:0]  dg, ug, vg_strap;
    logic [15:0] vg;
    wire         sda;
    int          failures, n_tests, i;
    ssitp_top #(.PG_CYC(17'h14), .DEB_CYC(22'h10)) ssitp_top_i (
        .CLK_SYS(clk), .RST_N(rst_n), .SUPPLY_OK(supply_ok), .SCL(scl),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
        .LANE_CONFIG_PINS(lane_pin), .ORIENTATION_PIN(orient_pin),
        .SERIAL_CFG_STRAP(1'b1), .DOWNSTREAM_GAIN_STRAP(4'hE),
        .UPSTREAM_GAIN_STRAP(4'h6), .VIDEO_LANE_GAIN_STRAP(vg_strap),
        .POWER_GOOD(pg), .SERIAL_CFG_SEL(sel), .LANE_CONFIG(lane_cfg),
        .ORIENTATION(orient), .LANE_SEL(lane_sel), .FLIP_SEL(flip),
        .HPD_FORCE(hpf), .HPD_SWAP(hps), .GAIN_OVERRIDE(gov),
        .DOWNSTREAM_GAIN(dg), .UPSTREAM_GAIN(ug), .VIDEO_GAIN(vg));
    ssitp_i2c_ctl ssitp_i2c_ctl_i (.clk(clk), .sda_oe_n(sda_oe_n),
        .sda_o(sda_o), .scl(scl), .sda(sda));
    // Compares a seen value with the expected one.
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Write: sub-address, then n data bytes, low byte first.
    task wr(input logic [7:0] sub, input logic [15:0] d, input int n);
        ssitp_i2c_ctl_i.start();
        ssitp_i2c_ctl_i.wbyte({DEV, 1'b0}, a);
        chk(16'(a), 16'h1);
        ssitp_i2c_ctl_i.wbyte(sub, a);
        chk(16'(a), 16'h1);
        for (int k = 0; k < n; k++) begin
            ssitp_i2c_ctl_i.wbyte(d[8*k+:8], a);
            chk(16'(a), 16'h1);
        end
        ssitp_i2c_ctl_i.stop();
    endtask
    // Read of n bytes from the pointer, the last one not acknowledged.
    task rd(input int n, input logic [15:0] exp);
        logic [7:0] b;
        ssitp_i2c_ctl_i.start();
        ssitp_i2c_ctl_i.wbyte({DEV, 1'b1}, a);
        chk(16'(a), 16'h1);
        for (int k = 0; k < n; k++) begin
            ssitp_i2c_ctl_i.rbyte(k == n - 1, b);
            chk(16'(b), 16'(exp[8*k+:8]));
        end
        ssitp_i2c_ctl_i.stop();
    endtask
    // Prints the counts and the verdict, then ends the run.
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // System clock of 200 MHz.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        summarize();
    end
    // Main sequence of tests.
    initial begin
        rst_n = 1'b0;
        supply_ok = 1'b0;
        orient_pin = 1'b0;
        lane_pin = 2'h0;
        vg_strap = 4'h9;
        failures = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        supply_ok <= 1'b1;
        for (i = 0; i < 200 && pg !== 1'b1; i++) @(posedge clk);
        chk(16'(i <= 30), 16'h1);
        repeat (2) @(posedge clk);
        chk(16'({sel, ug, dg}), 16'h16E);
        chk(vg, 16'h9999);
        $display("test power-up done");
        ssitp_i2c_ctl_i.start();
        ssitp_i2c_ctl_i.wbyte({7'h23, 1'b1}, a);
        chk(16'(a), 16'h0);
        ssitp_i2c_ctl_i.stop();
        rd(1, 16'h0000);
        wr(8'h0A, 16'h0, 0);
        rd(1, 16'h0001);
        $display("test address and pointer done");
        wr(8'h20, 16'h0, 0);
        rd(1, 16'h006E);
        wr(8'h0A, 16'h00F5, 1);
        chk(16'({hps, hpf, gov, flip, lane_sel}), 16'h2D);
        wr(8'h0A, 16'h0, 0);
        rd(1, 16'h0035);
        wr(8'h10, 16'h963C, 2);
        wr(8'h20, 16'h00A5, 1);
        repeat (2) @(posedge clk);
        chk(vg, 16'h963C);
        chk(16'({ug, dg}), 16'hA5);
        wr(8'h10, 16'h0, 0);
        rd(1, 16'h003C);
        rd(1, 16'h0096);
        wr(8'h20, 16'h0, 0);
        rd(2, 16'h00A5);
        $display("test write and read done");
        orient_pin <= 1'b1;
        repeat (5) @(posedge clk);
        orient_pin <= 1'b0;
        lane_pin <= 2'h2;
        for (i = 0; i < 60 && lane_cfg !== 2'h2; i++) @(posedge clk);
        chk(16'({i <= 26, lane_cfg, orient}), 16'hC);
        wr(8'h21, 16'h0, 0);
        rd(1, 16'h0009);
        wr(8'h21, 16'h0001, 1);
        wr(8'h21, 16'h0, 0);
        rd(1, 16'h0008);
        wr(8'h22, 16'h0005, 1);
        wr(8'h22, 16'h0002, 1);
        wr(8'h22, 16'h0, 0);
        rd(1, 16'h0007);
        $display("test debounce and field kinds done");
        summarize();
    end
endmodule
